// ### bench/instr_exec_checker.sv
// timing and effect assertions for the instruction executor
`timescale 1ns/1ps
module instr_exec_checker #(
    parameter int unsigned DATA_W = 8,
    parameter int unsigned INSTR_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic [DATA_W-1:0] acc,
    input wire logic zero_flag,
    input wire logic done,
    input wire logic unknown_op,
    input wire logic [DATA_W-1:0] file_rd_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // opcode class, forced to an unused code when idle
    wire logic [6:0] cls = instr_valid ? instr[11:5] : 7'h7F;
    wire logic [7:0] lit = instr[7:0];
    ////////////////////////////////////////
    // effects land two sampled edges after the word is taken
    property p_done; instr_valid |-> ##2 done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_lit; instr_valid && instr[11:8] == 4'hC |->
        ##2 acc == $past(lit, 2) && $stable(zero_flag); endproperty
    a_lit: assert property (p_lit) else $error("bad literal");
    property p_st; cls == 7'h01 |-> ##2 $stable(zero_flag) && $stable(acc);
    endproperty
    a_st: assert property (p_st) else $error("bad store");
    property p_nop; instr_valid && instr == 12'h000 |->
        ##2 $stable(acc) && $stable(zero_flag); endproperty
    a_nop: assert property (p_nop) else $error("bad nop");
    property p_cp0; cls == 7'h10 |->
        ##2 acc == file_rd_data && zero_flag == (acc == 8'h00); endproperty
    a_cp0: assert property (p_cp0) else $error("bad copy");
    property p_cp1; cls == 7'h11 |->
        ##2 $stable(acc) && zero_flag == (file_rd_data == 8'h00); endproperty
    a_cp1: assert property (p_cp1) else $error("bad test");
    property p_or0; cls == 7'h08 |-> ##2 acc == ($past(acc) | file_rd_data)
        && zero_flag == (acc == 8'h00); endproperty
    a_or0: assert property (p_or0) else $error("bad or");
    property p_or1; cls == 7'h09 |-> ##2 $stable(acc)
        && zero_flag == ((acc | file_rd_data) == 8'h00); endproperty
    a_or1: assert property (p_or1) else $error("bad or");
endmodule : instr_exec_checker
bind instr_exec instr_exec_checker #(.DATA_W(DATA_W), .INSTR_W(INSTR_W))
    u_instr_exec_checker (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr(instr), .acc(acc), .zero_flag(zero_flag), .done(done),
    .unknown_op(unknown_op), .file_rd_data(file_rd_data));

// ### bench/instr_exec_tb.sv
// self-checking bench for the instruction executor
`timescale 1ns/1ps
module instr_exec_tb;
    // row: word, acc, read data, pad, zero, unknown
    typedef struct packed {
        logic [11:0] i;
        logic [7:0] a;
        logic [7:0] r;
        logic [1:0] p;
        logic z;
        logic u;
    } row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    logic [11:0] instr = 12'h000;
    logic [7:0] acc, file_rd_data;
    logic zero_flag, done, unknown_op;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    row_t rows [20] = '{32'hC5A5A000, 32'h0235A000, 32'hC0000000,
        32'h223005A0, 32'h2035A5A0, 32'hC00005A0, 32'h024005A0, 32'h22400002,
        32'hC8181002, 32'h00081002, 32'h10481000, 32'h123815A0, 32'h203DBDB0,
        32'hC0000DB0, 32'h10400002, 32'hC3C3C002, 32'h03F3C002, 32'h21F3C3C0,
        32'h3E33C3C1, 32'h01F3C3C1};
    always #5 clk = ~clk;
    instr_exec u_instr_exec (.clk(clk), .rst_b(rst_b),
        .instr_valid(instr_valid), .instr(instr), .acc(acc),
        .zero_flag(zero_flag), .done(done), .unknown_op(unknown_op),
        .file_rd_data(file_rd_data));
    ////////////////////////////////////////
    task automatic chk(logic [18:0] exp);
        checks++;
        if ({done, acc, file_rd_data, zero_flag, unknown_op} !== exp) begin
            miscompares++;
            $display("ERROR %0t want %h", $time, exp);
        end
    endtask : chk
    // one word, then wait a bounded time for its retirement
    task automatic run(row_t x);
        int n;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= x.i;
        @(posedge clk);
        instr_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 4);
        chk({1'b1, x.a, x.r, x.z, x.u});
    endtask : run
    task automatic tally_and_finish();
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[k]) run(rows[k]);
        // back to back literals must retire on adjacent cycles
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= 12'hC11;
        @(posedge clk);
        instr <= 12'hC22;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk({1'b1, 8'h11, 8'h3C, 2'b00});
        @(posedge clk);
        #1;
        chk({1'b1, 8'h22, 8'h3C, 2'b00});
        // mid-run reset clears every visible register
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk(19'h00000);
        tally_and_finish();
    end
    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            miscompares++;
            tally_and_finish();
        end
    end
endmodule : instr_exec_tb

// ### hdl/exec_map.svh
// offsets, field positions and opcode codes for the five-instruction executor
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define OPC_TOP_LSB 6
`define OPC_OR_FILE 6'h04
`define OPC_COPY_FILE 6'h08
`define OPC_STORE_TOP 7'h01
`define OPC_LIT_TOP 4'hC
`define OPC_NOP 12'h000
`define DEST_BIT 5
`define FILE_MSB 4
`define FILE_DEPTH 32
`define LIT_MSB 7
`define ACC_RESET 8'h00
`define ZERO_RESET 1'b0
`endif

// ### hdl/exec_pkg.sv
// types for the five-instruction executor
package exec_pkg;
    typedef enum logic [2:0] {
        op_none,
        op_or_accumulator_with_file,
        op_copy_file_to_destination,
        op_load_literal_to_accumulator,
        op_store_accumulator_to_file,
        op_other
    } op_t;
    typedef struct packed {
        logic en;
        logic [4:0] addr;
        logic [7:0] data;
    } file_wr_t;
endpackage : exec_pkg

// ### hdl/file_ram.sv
// small 32 x 8 file register memory with registered read data
`timescale 1ns/1ps
module file_ram #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("file_ram: bad size");
        end
    end

    // read first, read registered; a same-cycle read sees the old value
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : file_ram

// ### hdl/instr_exec.sv
// decode and execute for or/copy/literal/store/nop instructions
`timescale 1ns/1ps
`include "exec_map.svh"

////////////////////////////////////////////////////////////////////////////
// Contract
// - 0001 00df ffff ORs accumulator with file, sets zero flag, one cycle.
// - OR with d=0 writes accumulator, file untouched.
// - OR with d=1 writes file, accumulator untouched.
// - 0010 00df ffff forwards file value unchanged, one cycle.
// - copy with d=0 writes accumulator.
// - copy with d=1 writes value back to same file.
// - copy sets zero flag when value zero, clears otherwise.
// - 0000 001f ffff stores accumulator to file, no flag change.
module instr_exec
    import exec_pkg::*;
#(
    parameter int unsigned DATA_W = 8,
    parameter int unsigned INSTR_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    output logic [DATA_W-1:0] acc,
    output logic zero_flag,
    output logic done,
    output logic unknown_op,
    output logic [DATA_W-1:0] file_rd_data
);
    initial begin
        if (DATA_W != 8 || INSTR_W != 12) begin
            $error("instr_exec: only 8-bit data, 12-bit opcodes");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode
    // opcode map served here, top bits first:
    //   0000 0000 0000  nop
    //   0000 001f ffff  store accumulator to file
    //   0001 00df ffff  or accumulator with file
    //   0010 00df ffff  copy file to destination
    //   1100 kkkk kkkk  load literal to accumulator
    //   anything else   retires with unknown_op and no effect,
    //                   including 0000 000x xxxx other than nop
    // nop is tested first so that the zero word never reaches the
    // store pattern check
    function automatic op_t decode_op(input logic [11:0] w);
        if (w == `OPC_NOP) begin
            decode_op = op_none;
        end else if (w[11:`OPC_TOP_LSB] == `OPC_OR_FILE) begin
            decode_op = op_or_accumulator_with_file;
        end else if (w[11:`OPC_TOP_LSB] == `OPC_COPY_FILE) begin
            decode_op = op_copy_file_to_destination;
        end else if (w[11:8] == `OPC_LIT_TOP) begin
            decode_op = op_load_literal_to_accumulator;
        end else if (w[11:5] == `OPC_STORE_TOP) begin
            decode_op = op_store_accumulator_to_file;
        end else begin
            decode_op = op_other;
        end
    endfunction : decode_op

    // low five bits pick one of the 32 file registers
    function automatic logic [4:0] file_addr(input logic [11:0] w);
        file_addr = w[`FILE_MSB:0];
    endfunction : file_addr

    // shared by or and copy, which both report a zero result
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction : is_zero

    ////////////////////////////////////////////////////////////////////////
    // two-stage flow: the file read needs one edge from the memory
    // stage_* holds the word between taking it and executing it
    logic stage_valid;
    logic [11:0] stage_instr;
    logic next_stage_valid;
    logic [11:0] next_stage_instr;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] next_acc;
    logic next_zero_flag;
    logic next_done;
    logic next_unknown_op;
    logic [DATA_W-1:0] next_file_rd_data;
    // single write port request, built afresh every cycle
    file_wr_t wr;
    op_t op;
    logic dest_file;
    logic [DATA_W-1:0] result;

    ////////////////////////////////////////////////////////////////////////
    // file memory; its read port follows the incoming word so that the
    // data is ready when that word reaches the execute stage
    file_ram #(
        .WIDTH(DATA_W),
        .DEPTH(`FILE_DEPTH)
    ) u_file (
        .clk(clk),
        .wr_en(wr.en),
        .wr_addr(wr.addr),
        .wr_data(wr.data),
        .rd_addr(file_addr(instr)),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // execute stage, one instruction per cycle
    // timing of one word:
    //   edge n   : word and valid taken, file read address applied
    //   edge n+1 : memory data ready, result written to acc or file,
    //              done and unknown_op pulse for one cycle
    // a word may follow every cycle; accumulator results forward
    // because the execute stage reads acc directly.
    // limitation: a file write by word n lands at edge n+1, while word
    // n+1 reads its file at that same edge and sees the old value; code
    // must keep one idle cycle or nop between a file write and a read
    // of the same address. no bypass, to keep the read path short.
    // defaults: hold state, no pulses, no write
    always_comb begin
        next_stage_valid = instr_valid;
        next_stage_instr = instr;
        next_acc = acc;
        next_zero_flag = zero_flag;
        next_done = 1'b0;
        next_unknown_op = 1'b0;
        next_file_rd_data = file_rd_data;
        op = decode_op(stage_instr);
        dest_file = stage_instr[`DEST_BIT];
        result = '0;
        wr = '0;
        if (stage_valid) begin
            next_done = 1'b1;
            unique case (op)
                op_or_accumulator_with_file: begin
                    result = acc | rd_data;
                    next_zero_flag = is_zero(result);
                    next_file_rd_data = rd_data;
                    if (dest_file) begin
                        wr.en = 1'b1;
                        wr.addr = file_addr(stage_instr);
                        wr.data = result;
                    end else begin
                        next_acc = result;
                    end
                end
                op_copy_file_to_destination: begin
                    result = rd_data;
                    next_file_rd_data = rd_data;
                    next_zero_flag = is_zero(result);
                    // write back same
                    // d=1 rewrites the same value, a cheap zero test
                    if (dest_file) begin
                        wr.en = 1'b1;
                        wr.addr = file_addr(stage_instr);
                        wr.data = result;
                    end else begin
                        next_acc = result;
                    end
                end
                op_load_literal_to_accumulator: begin
                    next_acc = stage_instr[`LIT_MSB:0];
                end
                op_store_accumulator_to_file: begin
                    wr.en = 1'b1;
                    wr.addr = file_addr(stage_instr);
                    wr.data = acc;
                end
                op_none: begin
                    next_acc = acc;
                end
                // words outside the five retire with no effect, so a
                // wider core can run them elsewhere in the same slot
                op_other: begin
                    next_unknown_op = 1'b1; // other jobs own these
                end
            endcase
        end
    end

    // registers only; synchronous active-low reset
    // a word taken on a reset edge is dropped and never retires; the
    // file memory is not cleared, so it is unknown until written
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage_valid <= 1'b0;
            stage_instr <= '0;
            acc <= `ACC_RESET;
            zero_flag <= `ZERO_RESET;
            done <= 1'b0;
            unknown_op <= 1'b0;
            file_rd_data <= '0;
        end else begin
            stage_valid <= next_stage_valid;
            stage_instr <= next_stage_instr;
            acc <= next_acc;
            zero_flag <= next_zero_flag;
            done <= next_done;
            unknown_op <= next_unknown_op;
            file_rd_data <= next_file_rd_data;
        end
    end
endmodule : instr_exec
